//--- rtl/rap_alarm_ctrl.sv
`timescale 1ns/1ps

module rap_alarm_ctrl
#(
  parameter int PULSE_CYC = rap_pkg::PULSE_OSC_CYC
)
(
  // system clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // crystal oscillator clock
  input  wire logic              osc_clk,
  // running time from the counters, update pulse once per second
  input  wire rap_pkg::rap_time_t run_time,
  input  wire logic              time_upd,
  // byte register port from the serial front end
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic              reg_rd_done,
  input  wire logic              reg_stop,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // user array write gate
  input  wire logic              arr_wr_req,
  input  wire logic [8:0]        arr_wr_addr,
  output logic                   arr_wr_en,
  output logic                   arr_wr_drop,
  // interrupt or clock output, active low
  output logic                   irq_or_clock_out_pin_n
);
  import rap_pkg::*;

  localparam int PC_W = $clog2(PULSE_CYC + 1);

  if (PULSE_CYC < 1)
  begin : g_bad_pulse
    $error("pulse length must be at least one oscillator cycle");
  end

  // address to alarm set and field
  function automatic rap_dec_t dec_alarm(input logic [15:0] a);
    rap_dec_t d;
    d = '0;
    d.hit = 1'b1;
    case (a)
      ALM0_SEC_OFS:   d.field = F_SEC;
      ALM0_MIN_OFS:   d.field = F_MIN;
      ALM0_HOUR_OFS:  d.field = F_HOUR;
      ALM0_DATE_OFS:  d.field = F_DATE;
      ALM0_MONTH_OFS: d.field = F_MONTH;
      ALM0_YEAR_OFS:  d.field = F_YEAR;
      ALM0_WDAY_OFS:  d.field = F_WDAY;
      ALM0_CENT_OFS:  d.field = F_CENT;
      ALM1_SEC_OFS:   d = '{1'b1, 1'b1, F_SEC};
      ALM1_MIN_OFS:   d = '{1'b1, 1'b1, F_MIN};
      ALM1_HOUR_OFS:  d = '{1'b1, 1'b1, F_HOUR};
      ALM1_DATE_OFS:  d = '{1'b1, 1'b1, F_DATE};
      ALM1_MONTH_OFS: d = '{1'b1, 1'b1, F_MONTH};
      ALM1_YEAR_OFS:  d = '{1'b1, 1'b1, F_YEAR};
      ALM1_WDAY_OFS:  d = '{1'b1, 1'b1, F_WDAY};
      ALM1_CENT_OFS:  d = '{1'b1, 1'b1, F_CENT};
      default:        d.hit = 1'b0;
    endcase
    return d;
  endfunction : dec_alarm

  // protect field against a user array address
  function automatic logic prot_hit(input logic [2:0] bp,
                                    input logic [8:0] a);
    logic h;
    h = 1'b0;
    case (bp)
      3'h0:    h = 1'b0;
      3'h1:    h = (a >= PROT_UQ_LO) && (a <= PROT_TOP);
      3'h2:    h = (a >= PROT_UH_LO) && (a <= PROT_TOP);
      3'h4:    h = (a <= PROT_4PG_HI);
      3'h5:    h = (a <= PROT_8PG_HI);
      3'h6:    h = (a <= PROT_16PG_HI);
      default: h = 1'b1; // 011 and 111 lock the full array
    endcase
    return h;
  endfunction : prot_hit

  logic              rst_q_r;
  logic              rst_n_r;
  logic              osc_rst_q_r;
  logic              osc_rst_n_r;
  logic [DIV_W-1:0]  div_cnt_r;
  logic [2:0]        osc_src;
  logic [2:0]        sync1_r;
  logic [2:0]        sync2_r;
  logic [2:0]        sync3_r;
  logic [2:0]        osc_lvl_r;
  logic              osc_prev_r;
  logic              osc_tick;
  logic [7:0]        alm_r [2][8];
  logic [2:0]        prot_cfg_r;
  logic [4:0]        irq_cfg_r;
  logic              wel_r;
  logic              register_write_latch_r;
  logic              ccr_wr_seen_r;
  logic [1:0]        al_flag_r;
  logic [1:0]        al_snap_r;
  logic              sr_rd_act_r;
  logic [1:0]        alarm_evt;
  logic [1:0]        al_en;
  logic              pulse_mode;
  rap_fo_t           fo_sel;
  logic [PC_W-1:0]   pulse_cnt_r;
  logic [7:0]        rdata_r;
  logic              arr_en_r;
  logic              arr_drop_r;
  logic              pin_n_r;
  logic [63:0]       run_flat;
  rap_dec_t          dec;
  logic              ccr_ok;

  assign run_flat   = run_time;
  assign dec        = dec_alarm(reg_addr);
  assign ccr_ok     = wel_r & register_write_latch_r;
  assign al_en      = {irq_cfg_r[IRQ_ALARM_ONE_IRQ_ENABLE_BIT - IRQ_FO_LO_BIT],
                       irq_cfg_r[IRQ_ALARM_ZERO_IRQ_ENABLE_BIT - IRQ_FO_LO_BIT]};
  assign pulse_mode = irq_cfg_r[IRQ_PULSE_BIT - IRQ_FO_LO_BIT];
  assign fo_sel     = rap_fo_t'(irq_cfg_r[IRQ_FO_HI_BIT - IRQ_FO_LO_BIT:0]);

  // reset release for the system domain
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_q_r <= 1'b1;
      rst_n_r <= rst_q_r;
    end
  end

  // reset release for the oscillator domain
  always_ff @(posedge osc_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_rst_q_r <= 1'b0;
      osc_rst_n_r <= 1'b0;
    end
    else
    begin
      osc_rst_q_r <= 1'b1;
      osc_rst_n_r <= osc_rst_q_r;
    end
  end

  // free-running divider on the crystal clock
  always_ff @(posedge osc_clk or negedge osc_rst_n_r)
  begin
    if (!osc_rst_n_r)
      div_cnt_r <= '0;
    else
      div_cnt_r <= div_cnt_r + 1'b1;
  end

  // the raw oscillator is sampled as data: at 200 MHz this costs only
  // a few ns of jitter on the 32.768kHz output
  assign osc_src = {div_cnt_r[DIV_1HZ_BIT], div_cnt_r[DIV_4K_BIT], osc_clk};

  // three-stage crossing per oscillator level; accepted once stages agree
  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_n_r)
    begin
      if (!rst_n_r)
      begin
        sync1_r[i]   <= 1'b0;
        sync2_r[i]   <= 1'b0;
        sync3_r[i]   <= 1'b0;
        osc_lvl_r[i] <= 1'b0;
      end
      else
      begin
        sync1_r[i] <= osc_src[i];
        sync2_r[i] <= sync1_r[i];
        sync3_r[i] <= sync2_r[i];
        if (sync2_r[i] == sync3_r[i])
          osc_lvl_r[i] <= sync3_r[i];
      end
    end
  end

  // oscillator edge count used to time interrupt pulses
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      osc_prev_r <= 1'b0;
    else
      osc_prev_r <= osc_lvl_r[0];
  end
  assign osc_tick = osc_lvl_r[0] & ~osc_prev_r;

  // alarm comparison per set, sampled only on the seconds update
  for (genvar s = 0; s < 2; s++)
  begin : g_match
    logic [7:0] f_ok;
    logic [7:0] f_en;
    for (genvar f = 0; f < 8; f++)
    begin : g_field
      // year and century carry no enable and never take part
      if (f == 5 || f == 7)
      begin : g_none
        assign f_en[f] = 1'b0;
        assign f_ok[f] = 1'b1;
      end
      else
      begin : g_cmp
        assign f_en[f] = alm_r[s][f][MATCH_EN_BIT];
        // same bit positions as the running byte, enable bit excluded
        assign f_ok[f] = !f_en[f] ||
                         (alm_r[s][f][6:0] ==
                          (run_flat[f*8 +: 7] & FIELD_MASK[f][6:0]));
      end
    end
    // any mix of enabled fields; a set with none enabled never fires
    assign alarm_evt[s] = time_upd && (|f_en) && (&f_ok);
  end

  // alarm bytes: kept across power loss by the retained supply domain,
  // so only the power-on reset restores the defaults
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      for (int s = 0; s < 2; s++)
        for (int f = 0; f < 8; f++)
          alm_r[s][f] <= (f == 7) ? CENT_RST : ALM_RST;
    end
    else if (reg_wr && dec.hit && ccr_ok && dec.field != F_YEAR)
      alm_r[dec.set][dec.field] <= reg_wdata & FIELD_MASK[dec.field];
  end

  // protect and interrupt configuration bytes, also retained
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      prot_cfg_r <= PROT_CFG_RST;
      irq_cfg_r  <= IRQ_CFG_RST;
    end
    else if (reg_wr && ccr_ok)
    begin
      if (reg_addr == PROT_CFG_OFS)
        prot_cfg_r <= reg_wdata[PROT_HI_BIT:PROT_LO_BIT];
      if (reg_addr == IRQ_CFG_OFS)
        irq_cfg_r <= reg_wdata[IRQ_PULSE_BIT:IRQ_FO_LO_BIT];
    end
  end

  // write latches: 02h arms, 06h after that opens, 00h closes both;
  // the register latch drops at the stop that ends a guarded write
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wel_r         <= 1'b0;
      register_write_latch_r        <= 1'b0;
      ccr_wr_seen_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == STATUS_OFS)
    begin
      case (reg_wdata)
        SR_CMD_CLR:
        begin
          wel_r  <= 1'b0;
          register_write_latch_r <= 1'b0;
        end
        SR_CMD_WEL:  wel_r  <= 1'b1;
        SR_CMD_REGISTER_WRITE_LATCH: register_write_latch_r <= wel_r;
        default:     wel_r  <= wel_r;
      endcase
    end
    else if (reg_stop)
    begin
      if (ccr_wr_seen_r)
        register_write_latch_r <= 1'b0;
      ccr_wr_seen_r <= 1'b0;
    end
    else if (reg_wr && ccr_ok)
      ccr_wr_seen_r <= 1'b1;
  end

  // alarm flags: a match in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      al_flag_r   <= 2'h0;
      al_snap_r   <= 2'h0;
      sr_rd_act_r <= 1'b0;
    end
    else
    begin
      if (reg_rd && reg_addr == STATUS_OFS)
      begin
        al_snap_r   <= al_flag_r;
        sr_rd_act_r <= 1'b1;
      end
      else if (reg_rd_done)
      begin
        al_snap_r   <= 2'h0;
        sr_rd_act_r <= 1'b0;
      end
      if (reg_rd_done && sr_rd_act_r)
        al_flag_r <= (al_flag_r & ~al_snap_r) | alarm_evt;
      else
        al_flag_r <= al_flag_r | alarm_evt;
    end
  end

  // register read data, one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      rdata_r <= 8'h00;
      if (dec.hit && dec.field == F_YEAR)
        rdata_r <= run_time.year;
      else if (dec.hit)
        rdata_r <= alm_r[dec.set][dec.field];
      else if (reg_addr == PROT_CFG_OFS)
        rdata_r[PROT_HI_BIT:PROT_LO_BIT] <= prot_cfg_r;
      else if (reg_addr == IRQ_CFG_OFS)
        rdata_r[IRQ_PULSE_BIT:IRQ_FO_LO_BIT] <= irq_cfg_r;
      else if (reg_addr == STATUS_OFS)
      begin
        rdata_r[SR_AL1_BIT]  <= al_flag_r[1];
        rdata_r[SR_AL0_BIT]  <= al_flag_r[0];
        rdata_r[SR_REGISTER_WRITE_LATCH_BIT] <= register_write_latch_r;
        rdata_r[SR_WEL_BIT]  <= wel_r;
      end
    end
  end

  // user array write gate, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      arr_en_r   <= 1'b0;
      arr_drop_r <= 1'b0;
    end
    else
    begin
      arr_en_r   <= arr_wr_req && !prot_hit(prot_cfg_r, arr_wr_addr);
      arr_drop_r <= arr_wr_req && prot_hit(prot_cfg_r, arr_wr_addr);
    end
  end

  // pulse timer; coincident alarms in one second share one pulse
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      pulse_cnt_r <= '0;
    else if (pulse_mode && fo_sel == FO_ALARM && |(alarm_evt & al_en))
      pulse_cnt_r <= PC_W'(PULSE_CYC);
    else if (osc_tick && pulse_cnt_r != '0)
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
  end

  // shared output pin: frequency selection takes the pin from the alarms
  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      pin_n_r <= 1'b1;
    else
    begin
      case (fo_sel)
        FO_ALARM:
          if (pulse_mode)
            pin_n_r <= (pulse_cnt_r == '0);
          else
            pin_n_r <= ~|(al_flag_r & al_en);
        FO_32K:  pin_n_r <= osc_lvl_r[0];
        FO_4K:   pin_n_r <= osc_lvl_r[1];
        FO_1HZ:  pin_n_r <= osc_lvl_r[2];
        default: pin_n_r <= 1'b1;
      endcase
    end
  end

  assign reg_rdata              = rdata_r;
  assign arr_wr_en              = arr_en_r;
  assign arr_wr_drop            = arr_drop_r;
  assign irq_or_clock_out_pin_n = pin_n_r;

endmodule : rap_alarm_ctrl

//--- inc/rap_pkg.sv
package rap_pkg;

  // register offsets on the byte-wide register port
  localparam logic [15:0] ALM0_SEC_OFS   = 16'h0000;
  localparam logic [15:0] ALM0_MIN_OFS   = 16'h0001;
  localparam logic [15:0] ALM0_HOUR_OFS  = 16'h0002;
  localparam logic [15:0] ALM0_DATE_OFS  = 16'h0003;
  localparam logic [15:0] ALM0_MONTH_OFS = 16'h0004;
  localparam logic [15:0] ALM0_YEAR_OFS  = 16'h0005;
  localparam logic [15:0] ALM0_WDAY_OFS  = 16'h0006;
  localparam logic [15:0] ALM0_CENT_OFS  = 16'h0007;
  localparam logic [15:0] ALM1_MIN_OFS   = 16'h0009;
  localparam logic [15:0] ALM1_HOUR_OFS  = 16'h000a;
  localparam logic [15:0] ALM1_DATE_OFS  = 16'h000b;
  localparam logic [15:0] ALM1_MONTH_OFS = 16'h000c;
  localparam logic [15:0] ALM1_YEAR_OFS  = 16'h000d;
  localparam logic [15:0] ALM1_WDAY_OFS  = 16'h000e;
  localparam logic [15:0] ALM1_CENT_OFS  = 16'h000f;
  localparam logic [15:0] ALM1_SEC_OFS   = 16'h8000;
  localparam logic [15:0] PROT_CFG_OFS   = 16'h0010;
  localparam logic [15:0] IRQ_CFG_OFS    = 16'h0011;
  localparam logic [15:0] STATUS_OFS     = 16'h003f;

  // alarm field index inside one set
  localparam logic [2:0] F_SEC   = 3'h0;
  localparam logic [2:0] F_MIN   = 3'h1;
  localparam logic [2:0] F_HOUR  = 3'h2;
  localparam logic [2:0] F_DATE  = 3'h3;
  localparam logic [2:0] F_MONTH = 3'h4;
  localparam logic [2:0] F_YEAR  = 3'h5;
  localparam logic [2:0] F_WDAY  = 3'h6;
  localparam logic [2:0] F_CENT  = 3'h7;

  // writable bits per field, index 0 = seconds
  localparam logic [7:0][7:0] FIELD_MASK = {8'h39, 8'h87, 8'h00, 8'h9f,
                                            8'hbf, 8'hbf, 8'hff, 8'hff};
  localparam int MATCH_EN_BIT = 7;

  // field positions of the configuration and status bytes
  localparam int IRQ_PULSE_BIT = 7;
  localparam int IRQ_ALARM_ONE_IRQ_ENABLE_BIT  = 6;
  localparam int IRQ_ALARM_ZERO_IRQ_ENABLE_BIT  = 5;
  localparam int IRQ_FO_HI_BIT = 4;
  localparam int IRQ_FO_LO_BIT = 3;
  localparam int PROT_HI_BIT   = 7;
  localparam int PROT_LO_BIT   = 5;
  localparam int SR_AL1_BIT    = 6;
  localparam int SR_AL0_BIT    = 5;
  localparam int SR_REGISTER_WRITE_LATCH_BIT   = 2;
  localparam int SR_WEL_BIT    = 1;

  // status write commands
  localparam logic [7:0] SR_CMD_CLR  = 8'h00;
  localparam logic [7:0] SR_CMD_WEL  = 8'h02;
  localparam logic [7:0] SR_CMD_REGISTER_WRITE_LATCH = 8'h06;

  // reset values
  localparam logic [7:0] ALM_RST      = 8'h00;
  localparam logic [7:0] CENT_RST     = 8'h20;
  localparam logic [2:0] PROT_CFG_RST = 3'h0;
  localparam logic [4:0] IRQ_CFG_RST  = 5'h00;

  // protected user array ranges
  localparam logic [8:0] PROT_TOP     = 9'h1ff;
  localparam logic [8:0] PROT_UQ_LO   = 9'h180;
  localparam logic [8:0] PROT_UH_LO   = 9'h100;
  localparam logic [8:0] PROT_4PG_HI  = 9'h03f;
  localparam logic [8:0] PROT_8PG_HI  = 9'h07f;
  localparam logic [8:0] PROT_16PG_HI = 9'h0ff;

  // oscillator divider taps and pulse length in oscillator cycles
  localparam int DIV_W         = 15;
  localparam int DIV_4K_BIT    = 2;
  localparam int DIV_1HZ_BIT   = 14;
  localparam int PULSE_OSC_CYC = 8;

  // output pin source selection, in select-bit order
  typedef enum logic [1:0] {FO_ALARM, FO_32K, FO_4K, FO_1HZ} rap_fo_t;

  // running time bytes, seconds in the low byte
  typedef struct packed {
    logic [7:0] cent;
    logic [7:0] wday;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rap_time_t;

  // decoded alarm address
  typedef struct packed {
    logic       hit;
    logic       set;
    logic [2:0] field;
  } rap_dec_t;

endpackage : rap_pkg

//--- tb/rap_alarm_sva.sv
`timescale 1ns/1ps
module rap_alarm_sva
  import rap_pkg::*;
(
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               arst_n,
  // time and register port
  input wire rap_pkg::rap_time_t run_time,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_addr,
  input wire logic [7:0]         reg_rdata,
  // array gate and pin
  input wire logic               arr_wr_req,
  input wire logic               arr_wr_en,
  input wire logic               arr_wr_drop,
  input wire logic               irq_or_clock_out_pin_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // every array write gets exactly one verdict, never both
  a_gate_one_shot: assert property (
    arr_wr_req |=> arr_wr_en != arr_wr_drop)
    else $error("array write got no single verdict");
  a_gate_idle: assert property (
    !arr_wr_req |=> !arr_wr_en && !arr_wr_drop)
    else $error("array verdict without a request");
  // read data stands between reads
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_year_run: assert property (
    reg_rd && reg_addr == ALM1_YEAR_OFS |=> reg_rdata == $past(run_time.year))
    else $error("year alarm slot not showing running year");
  a_status_fixed: assert property (
    reg_rd && reg_addr == STATUS_OFS |=> (reg_rdata & 8'h99) == 8'h00)
    else $error("status byte has bits outside its fields");
  a_latch_order: assert property (
    reg_rd && reg_addr == STATUS_OFS
    |=> !reg_rdata[SR_REGISTER_WRITE_LATCH_BIT] || reg_rdata[SR_WEL_BIT])
    else $error("register latch set without write latch");
  // alarm bytes keep the time byte layout
  a_month_layout: assert property (
    reg_rd && reg_addr == ALM0_MONTH_OFS |=> (reg_rdata & 8'h60) == 8'h00)
    else $error("month alarm holds undefined bits");
  a_wday_layout: assert property (
    reg_rd && reg_addr == ALM1_WDAY_OFS |=> (reg_rdata & 8'h78) == 8'h00)
    else $error("weekday alarm holds undefined bits");

  // main scenarios reached
  c_flag_read: cover property (
    reg_rd && reg_addr == STATUS_OFS ##1 reg_rdata[SR_AL0_BIT]);
  c_drop: cover property (arr_wr_drop);
  c_pin_low: cover property ($fell(irq_or_clock_out_pin_n));
endmodule : rap_alarm_sva

bind rap_alarm_ctrl rap_alarm_sva u_sva (
  .sys_clk(sys_clk), .arst_n(arst_n), .run_time(run_time),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .arr_wr_req(arr_wr_req), .arr_wr_en(arr_wr_en),
  .arr_wr_drop(arr_wr_drop),
  .irq_or_clock_out_pin_n(irq_or_clock_out_pin_n));

//--- tb/rap_host_model.sv
`timescale 1ns/1ps
module rap_host_model
  import rap_pkg::*;
(
  // system clock
  input  wire logic       sys_clk,
  // register port toward the device
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            reg_rd_done,
  output logic            reg_stop,
  output logic [15:0]     reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // extra idle cycles between transfers, raised to act as a slow host
  int gap = 0;

  // bus idle at time zero
  initial
  begin
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_rd_done = 1'b0;
    reg_stop    = 1'b0;
    reg_addr    = 16'h0000;
    reg_wdata   = 8'h00;
  end

  task automatic idle();
    repeat (gap + 1) @(posedge sys_clk);
    #1;
  endtask : idle

  // released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    idle();
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic stop();
    idle();
    reg_stop = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_stop = 1'b0;
  endtask : stop

  // data taken the cycle after the strobe, then the last bit ends the read
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    idle();
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd      = 1'b0;
    reg_addr    = ~a;
    d           = reg_rdata;
    reg_rd_done = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd_done = 1'b0;
  endtask : rd

  // unlock sequence, each step its own transaction
  task automatic gwr(input logic [15:0] a, input logic [7:0] d);
    wr(STATUS_OFS, SR_CMD_WEL);
    stop();
    wr(STATUS_OFS, SR_CMD_REGISTER_WRITE_LATCH);
    stop();
    wr(a, d);
    stop();
  endtask : gwr
endmodule : rap_host_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rap_pkg::*;
  localparam int PCYC = 2;

  logic        sys_clk, osc_clk, arst_n, time_upd, pin_n;
  logic        reg_wr, reg_rd, reg_rd_done, reg_stop;
  logic        arr_wr_req, arr_wr_en, arr_wr_drop;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d, e;
  logic [8:0]  arr_wr_addr;
  rap_time_t   run_time;
  int          n_fail, n_checks, lo, tg;
  logic [15:0] ro [19] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
    16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0009, 16'h000a, 16'h000b,
    16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h8000, 16'h0010, 16'h0011,
    16'h0008};
  logic [8:0]  pa [10] = '{9'h000, 9'h03f, 9'h040, 9'h07f, 9'h080, 9'h0ff,
    9'h100, 9'h17f, 9'h180, 9'h1ff};

  rap_alarm_ctrl #(.PULSE_CYC(PCYC)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .osc_clk(osc_clk),
    .run_time(run_time), .time_upd(time_upd), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_done(reg_rd_done), .reg_stop(reg_stop),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .arr_wr_req(arr_wr_req), .arr_wr_addr(arr_wr_addr),
    .arr_wr_en(arr_wr_en), .arr_wr_drop(arr_wr_drop),
    .irq_or_clock_out_pin_n(pin_n));
  rap_host_model host (
    .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_done(reg_rd_done), .reg_stop(reg_stop), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // 200 MHz system clock, 32 ns oscillator with its own phase
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    osc_clk = 1'b0;
    #3;
    forever #16 osc_clk = ~osc_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the thousand or so cycles the run needs
  initial
  begin
    #300000;
    n_fail++;
    tally_and_finish();
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] x,
                      input string m);
    n_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, g, x);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic x, input string m);
    chk8({7'h00, g}, {7'h00, x}, m);
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // one-second update with new seconds and minutes
  task automatic upd(input logic [7:0] s, input logic [7:0] m);
    run_time.sec = s;
    run_time.min = m;
    tick(1);
    time_upd = 1'b1;
    tick(1);
    time_upd = 1'b0;
  endtask : upd

  // counts low cycles and level changes of the pin over a window
  task automatic watch(output int l, output int t);
    logic p;
    l = 0;
    t = 0;
    p = pin_n;
    repeat (80)
    begin
      tick(1);
      if (pin_n !== 1'b1) l++;
      if (pin_n !== p) t++;
      p = pin_n;
    end
  endtask : watch

  task automatic arr(input logic [8:0] a, input logic drop);
    arr_wr_addr = a;
    arr_wr_req  = 1'b1;
    tick(1);
    arr_wr_req = 1'b0;
    chk1(arr_wr_en, !drop, "array allow");
    chk1(arr_wr_drop, drop, "array drop");
    tick(1);
  endtask : arr

  function automatic logic prot_exp(input logic [2:0] c, input logic [8:0] a);
    case (c)
      3'h0: return 1'b0;
      3'h1: return a >= PROT_UQ_LO;
      3'h2: return a >= PROT_UH_LO;
      3'h4: return a <= PROT_4PG_HI;
      3'h5: return a <= PROT_8PG_HI;
      3'h6: return a <= PROT_16PG_HI;
      default: return 1'b1;
    endcase
  endfunction : prot_exp

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    time_upd = 1'b0;
    arr_wr_req = 1'b0;
    arr_wr_addr = 9'h000;
    run_time = '0;
    run_time.year = 8'h24;
    n_fail = 0;
    n_checks = 0;
    repeat (12) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    tick(3);
    foreach (ro[i])
    begin
      e = (ro[i] == ALM0_CENT_OFS || ro[i] == ALM1_CENT_OFS) ? CENT_RST :
          (ro[i] == ALM0_YEAR_OFS || ro[i] == ALM1_YEAR_OFS) ? 8'h24 : ALM_RST;
      host.rd(ro[i], d);
      chk8(d, e, "reset value");
    end
    host.wr(IRQ_CFG_OFS, 8'h20);
    host.stop();
    host.rd(IRQ_CFG_OFS, d);
    chk8(d, 8'h00, "unlocked write");
    host.gap = 2;
    host.gwr(ALM0_SEC_OFS, 8'h95);
    host.gwr(ALM0_MIN_OFS, 8'hb0);
    host.gap = 0;
    host.rd(ALM0_MIN_OFS, d);
    chk8(d, 8'hb0, "alarm byte stored");
    upd(8'h15, 8'h30);
    tick(3);
    chk1(pin_n, 1'b1, "pin without enable");
    host.rd(STATUS_OFS, d);
    chk8(d & 8'h66, 8'h22, "flag and latches");
    host.gwr(IRQ_CFG_OFS, 8'h20);
    upd(8'h15, 8'h00);
    tick(3);
    chk1(pin_n, 1'b1, "partial match");
    host.rd(STATUS_OFS, d);
    chk8(d & 8'h60, 8'h00, "flag cleared, no match");
    upd(8'h15, 8'h30);
    tick(20);
    chk1(pin_n, 1'b0, "single event held");
    host.rd(STATUS_OFS, d);
    chk8(d & 8'h60, 8'h20, "alarm flag");
    tick(3);
    chk1(pin_n, 1'b1, "released by read");
    host.gwr(IRQ_CFG_OFS, 8'ha0);
    repeat (2)
    begin
      upd(8'h15, 8'h30);
      watch(lo, tg);
      chk1(lo > 0, 1'b1, "pulse seen");
      chk1(lo <= PCYC * 7 + 6 && pin_n, 1'b1, "pulse released");
    end
    host.gwr(ALM1_SEC_OFS, 8'ha0);
    host.gwr(IRQ_CFG_OFS, 8'he0);
    upd(8'h20, 8'h00);
    watch(lo, tg);
    chk1(lo > 0, 1'b1, "second alarm pulse");
    host.rd(STATUS_OFS, d);
    chk8(d & 8'h40, 8'h40, "second alarm flag");
    for (int s = 1; s < 4; s++)
    begin
      host.gwr(IRQ_CFG_OFS, {3'h1, s[1:0], 3'h0});
      upd(8'h15, 8'h30);
      watch(lo, tg);
      chk1(tg > 0, s != 3, "frequency output");
    end
    for (int c = 0; c < 8; c++)
    begin
      host.gwr(PROT_CFG_OFS, {c[2:0], 5'h00});
      host.rd(PROT_CFG_OFS, d);
      chk8(d, {c[2:0], 5'h00}, "protect readback");
      foreach (pa[i])
        arr(pa[i], prot_exp(c[2:0], pa[i]));
    end
    tally_and_finish();
  end
endmodule : tb_top
